// file: core/ctu_pkg.sv
// Purpose: Shared types and constants for the cascaded trigger units.
// Assumes: One 50 MHz clock; all windows and pulse widths count clock cycles.
// Notes:   Each unit takes six configuration words, first index below.

`default_nettype none

package ctu_pkg;

    // ********************************************************************
    // Widths, indices and constants
    // ********************************************************************
    localparam int unsigned CTU_W            = 16;
    localparam int unsigned CTU_U1_REG_FIRST = 40;
    localparam int unsigned CTU_U1_REG_LAST  = 45;
    localparam int unsigned CTU_U2_REG_FIRST = 46;
    localparam int unsigned CTU_U2_REG_LAST  = 51;

    typedef logic [CTU_W-1:0] ctu_word_t;

    localparam ctu_word_t CTU_ZERO = 16'h0000;
    localparam ctu_word_t CTU_ONE  = 16'h0001;
    localparam ctu_word_t CTU_MAX  = 16'hFFFF;

    // ********************************************************************
    // Modes
    // ********************************************************************
    typedef enum logic [2:0] {
        CTU_SRC_FBW,
        CTU_SRC_TMR,
        CTU_SRC_ANA,
        CTU_SRC_DIN,
        CTU_SRC_U1
    } ctu_src_t;

    typedef enum logic [2:0] {
        CTU_EVT_RISE,
        CTU_EVT_FALL,
        CTU_EVT_PLONG,
        CTU_EVT_PSHORT,
        CTU_EVT_NLONG,
        CTU_EVT_NSHORT
    } ctu_evt_t;

    typedef enum logic [1:0] {
        CTU_ENA_ALWAYS,
        CTU_ENA_ANA,
        CTU_ENA_DIN
    } ctu_ena_t;

    typedef enum logic [2:0] {
        CTU_ACT_NONE,
        CTU_ACT_REC,
        CTU_ACT_CHRONO,
        CTU_ACT_DOUT,
        CTU_ACT_SAVE,
        CTU_ACT_CLR,
        CTU_ACT_VTT
    } ctu_act_t;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        ctu_src_t  src;
        ctu_evt_t  evt;
        ctu_ena_t  ena;
        logic      en_neg;
        ctu_act_t  act;
        ctu_word_t trg_thr;
        ctu_word_t pulse_w;
        ctu_word_t en_thr;
        ctu_word_t vtt;
    } ctu_cfg_t;

    typedef struct packed {
        ctu_word_t fb_word;
        ctu_word_t analog;
    } ctu_smp_t;

endpackage

`default_nettype wire

// file: core/ctu_trig_unit.sv
// Purpose: One trigger unit: source level, event detector and enable gate.
// Assumes: Sample words and the digital input are already in the clock domain.
// Notes:   Glitch widths are counted in clock cycles of the sampled level.

`default_nettype none

module ctu_trig_unit (
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire ctu_pkg::ctu_cfg_t cfg_i,
    input  wire ctu_pkg::ctu_smp_t smp_i,
    input  wire ctu_pkg::ctu_word_t timer_i,
    input  wire logic              din_i,
    input  wire logic              casc_lvl_i,
    input  wire logic              allow_i,
    input  wire logic              clear_i,
    output logic                   lvl_o,
    output logic                   fire_o
);

    // ********************************************************************
    // Source level and event detection
    // ********************************************************************
    logic               lvl_d;
    logic               lvl_q;
    logic               lvl_p_q;
    logic               pol;
    logic               in_pol;
    logic               ended;
    logic               rise;
    logic               fall;
    logic               g_long;
    logic               g_short;
    logic               evt;
    logic               ana_hi;
    logic               gate;
    ctu_pkg::ctu_word_t wid_d;
    ctu_pkg::ctu_word_t wid_q;

    assign lvl_d = (cfg_i.src == ctu_pkg::CTU_SRC_FBW) ? (smp_i.fb_word >= cfg_i.trg_thr) :
                   (cfg_i.src == ctu_pkg::CTU_SRC_TMR) ? (timer_i >= cfg_i.trg_thr) :
                   (cfg_i.src == ctu_pkg::CTU_SRC_ANA) ?
                       ($signed(smp_i.analog) >= $signed(cfg_i.trg_thr)) :
                   (cfg_i.src == ctu_pkg::CTU_SRC_DIN) ? din_i :
                   casc_lvl_i;

    assign rise = lvl_q && !lvl_p_q;
    assign fall = !lvl_q && lvl_p_q;

    assign pol     = (cfg_i.evt == ctu_pkg::CTU_EVT_PLONG) ||
                     (cfg_i.evt == ctu_pkg::CTU_EVT_PSHORT);
    assign in_pol  = (lvl_q == pol);
    assign ended   = (lvl_p_q == pol) && !in_pol && !clear_i;
    assign g_long  = ended && (wid_q > cfg_i.pulse_w);
    assign g_short = ended && (wid_q < cfg_i.pulse_w);

    assign evt = (cfg_i.evt == ctu_pkg::CTU_EVT_RISE)   ? rise :
                 (cfg_i.evt == ctu_pkg::CTU_EVT_FALL)   ? fall :
                 ((cfg_i.evt == ctu_pkg::CTU_EVT_PLONG) ||
                  (cfg_i.evt == ctu_pkg::CTU_EVT_NLONG)) ? g_long :
                 ((cfg_i.evt == ctu_pkg::CTU_EVT_PSHORT) ||
                  (cfg_i.evt == ctu_pkg::CTU_EVT_NSHORT)) ? g_short : 1'b0;

    // The width counter saturates so that a very long pulse never wraps short.
    assign wid_d = (clear_i || !in_pol) ? ctu_pkg::CTU_ZERO :
                   (wid_q == ctu_pkg::CTU_MAX) ? wid_q : wid_q + ctu_pkg::CTU_ONE;

    // ********************************************************************
    // Enable gate
    // ********************************************************************
    assign ana_hi = $signed(smp_i.analog) >= $signed(cfg_i.en_thr);
    assign gate   = (cfg_i.ena == ctu_pkg::CTU_ENA_ALWAYS) ? 1'b1 :
                    (cfg_i.ena == ctu_pkg::CTU_ENA_ANA) ? (ana_hi ^ cfg_i.en_neg) :
                    (din_i ^ cfg_i.en_neg);
    assign fire_o = evt && gate && allow_i;
    assign lvl_o  = lvl_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            lvl_q   <= 1'b0;
            lvl_p_q <= 1'b0;
            wid_q   <= ctu_pkg::CTU_ZERO;
        end else begin
            lvl_q   <= lvl_d;
            lvl_p_q <= lvl_q;
            wid_q   <= wid_d;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    a_source_din: assert property (
        $past(reset_n_i) && $past(cfg_i.src) == ctu_pkg::CTU_SRC_DIN |-> lvl_q == $past(din_i))
        else $error("Digital source level not followed.");
    a_source_casc: assert property (
        $past(reset_n_i) && $past(cfg_i.src) == ctu_pkg::CTU_SRC_U1 |->
        lvl_q == $past(casc_lvl_i))
        else $error("Cascade source level not followed.");
    a_rise_event: assert property (
        cfg_i.evt == ctu_pkg::CTU_EVT_RISE && $rose(lvl_q) |-> evt)
        else $error("Rising edge missed.");
    a_glitch_short: assert property (
        evt && cfg_i.evt == ctu_pkg::CTU_EVT_PSHORT |-> $fell(lvl_q) && wid_q < cfg_i.pulse_w)
        else $error("Short positive glitch reported wrongly.");
    a_gate_always: assert property (
        cfg_i.ena == ctu_pkg::CTU_ENA_ALWAYS && evt && allow_i |-> fire_o)
        else $error("Ungated event not passed.");
    a_gate_din: assert property (
        fire_o && cfg_i.ena == ctu_pkg::CTU_ENA_DIN |-> din_i != cfg_i.en_neg)
        else $error("Event passed against digital gate.");

endmodule

`default_nettype wire

// file: core/ctu_top.sv
// Purpose: Two cascadable trigger units of one channel with their actions.
// Assumes: Configuration and sample words come from logic on mclk_i.
// Notes:   The trigger pin is asynchronous and is synchronised here.
//
// Function
// - Two trigger units per channel, configured by words 40-45 and 46-51.
// - Each unit picks its source: fieldbus word, timer, analog, digital input.
// - Unit 2 may take unit 1 output as source, forming a cascade.
// - Rising and falling edges are selectable trigger events.
// - Glitch events: positive or negative pulse longer or shorter than set width.
// - Enable mode always passes every detected event straight to actions, except unit 2 events outside the cascade window.
// - Otherwise events gate on analog or digital level, either polarity.
// - Action may start recording, start the chronometer or set the output.
// - Action may store the timer value or clear the timer.
// - Action may start a separate timer lasting the valid trigger time.
// - In cascade, unit 2 events count only inside the window after unit 1.
// - Window expiry without unit 2 event resets the cascade.

`default_nettype none

module ctu_top (
    input  wire logic               mclk_i,
    input  wire logic               reset_n_i,
    input  wire ctu_pkg::ctu_cfg_t  u1_cfg_i,
    input  wire ctu_pkg::ctu_cfg_t  u2_cfg_i,
    input  wire ctu_pkg::ctu_smp_t  smp_i,
    input  wire logic               trig_pin_i,
    input  wire logic               dout_clr_i,
    output logic                    rec_start_o,
    output logic                    chrono_run_o,
    output ctu_pkg::ctu_word_t      chrono_o,
    output ctu_pkg::ctu_word_t      saved_o,
    output logic                    dout_o,
    output logic                    vtt_busy_o,
    output logic                    armed_o,
    output logic                    u1_fire_o,
    output logic                    u2_fire_o
);

    // ********************************************************************
    // Trigger pin synchroniser
    // ********************************************************************
    logic din_m_q;
    logic din_s_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            din_m_q <= 1'b0;
            din_s_q <= 1'b0;
        end else begin
            din_m_q <= trig_pin_i;
            din_s_q <= din_m_q;
        end
    end

    // ********************************************************************
    // The two units
    // ********************************************************************
    logic               cascade;
    logic               u1_lvl;
    logic               u1_fire;
    logic               u2_fire;
    logic               u2_allow;
    logic               u2_clear;
    logic               armed_d;
    logic               armed_q;
    logic               arm;
    logic               win_exp;
    ctu_pkg::ctu_word_t win_d;
    ctu_pkg::ctu_word_t win_q;
    ctu_pkg::ctu_word_t chrono_d;
    ctu_pkg::ctu_word_t chrono_q;

    assign cascade  = (u2_cfg_i.src == ctu_pkg::CTU_SRC_U1);
    assign u2_allow = !cascade || armed_q;
    assign u2_clear = cascade && !armed_q;

    ctu_trig_unit u_unit1 (
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .cfg_i      (u1_cfg_i),
        .smp_i      (smp_i),
        .timer_i    (chrono_q),
        .din_i      (din_s_q),
        .casc_lvl_i (1'b0),
        .allow_i    (1'b1),
        .clear_i    (1'b0),
        .lvl_o      (u1_lvl),
        .fire_o     (u1_fire)
    );

    ctu_trig_unit u_unit2 (
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .cfg_i      (u2_cfg_i),
        .smp_i      (smp_i),
        .timer_i    (chrono_q),
        .din_i      (din_s_q),
        .casc_lvl_i (u1_lvl),
        .allow_i    (u2_allow),
        .clear_i    (u2_clear),
        .lvl_o      (),
        .fire_o     (u2_fire)
    );

    // ********************************************************************
    // Cascade window
    // ********************************************************************
    // A zero window never arms, so a cascade with no time set stays idle.
    assign arm     = cascade && u1_fire && (u1_cfg_i.vtt != ctu_pkg::CTU_ZERO);
    assign win_exp = armed_q && (win_q == ctu_pkg::CTU_ONE) && !u2_fire;
    assign armed_d = arm ? 1'b1 :
                     (u2_fire || win_exp || !cascade) ? 1'b0 : armed_q;
    assign win_d   = arm ? u1_cfg_i.vtt :
                     armed_d ? win_q - ctu_pkg::CTU_ONE : ctu_pkg::CTU_ZERO;

    // ********************************************************************
    // Actions
    // ********************************************************************
    logic               do_rec;
    logic               do_chrono;
    logic               do_dout;
    logic               do_save;
    logic               do_clr;
    logic               u1_vtt;
    logic               u2_vtt;
    logic               do_vtt;
    logic               run_q;
    logic               dout_q;
    logic               vtt_busy_q;
    ctu_pkg::ctu_word_t vtt_load;
    ctu_pkg::ctu_word_t vtt_d;
    ctu_pkg::ctu_word_t vtt_q;
    ctu_pkg::ctu_word_t saved_q;

    assign do_rec    = (u1_fire && u1_cfg_i.act == ctu_pkg::CTU_ACT_REC) ||
                       (u2_fire && u2_cfg_i.act == ctu_pkg::CTU_ACT_REC);
    assign do_chrono = (u1_fire && u1_cfg_i.act == ctu_pkg::CTU_ACT_CHRONO) ||
                       (u2_fire && u2_cfg_i.act == ctu_pkg::CTU_ACT_CHRONO);
    assign do_dout   = (u1_fire && u1_cfg_i.act == ctu_pkg::CTU_ACT_DOUT) ||
                       (u2_fire && u2_cfg_i.act == ctu_pkg::CTU_ACT_DOUT);
    assign do_save   = (u1_fire && u1_cfg_i.act == ctu_pkg::CTU_ACT_SAVE) ||
                       (u2_fire && u2_cfg_i.act == ctu_pkg::CTU_ACT_SAVE);
    assign do_clr    = (u1_fire && u1_cfg_i.act == ctu_pkg::CTU_ACT_CLR) ||
                       (u2_fire && u2_cfg_i.act == ctu_pkg::CTU_ACT_CLR);
    assign u1_vtt    = u1_fire && u1_cfg_i.act == ctu_pkg::CTU_ACT_VTT;
    assign u2_vtt    = u2_fire && u2_cfg_i.act == ctu_pkg::CTU_ACT_VTT;
    assign do_vtt    = u1_vtt || u2_vtt;
    assign vtt_load  = u2_vtt ? u2_cfg_i.vtt : u1_cfg_i.vtt;

    // Clear beats counting, so a clear lands on zero even while running.
    assign chrono_d = do_clr ? ctu_pkg::CTU_ZERO :
                      run_q ? chrono_q + ctu_pkg::CTU_ONE : chrono_q;
    assign vtt_d    = do_vtt ? vtt_load :
                      (vtt_q != ctu_pkg::CTU_ZERO) ? vtt_q - ctu_pkg::CTU_ONE : vtt_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            armed_q    <= 1'b0;
            win_q      <= ctu_pkg::CTU_ZERO;
            run_q      <= 1'b0;
            chrono_q   <= ctu_pkg::CTU_ZERO;
            saved_q    <= ctu_pkg::CTU_ZERO;
            dout_q     <= 1'b0;
            vtt_q      <= ctu_pkg::CTU_ZERO;
            vtt_busy_q <= 1'b0;
        end else begin
            armed_q    <= armed_d;
            win_q      <= win_d;
            run_q      <= run_q || do_chrono;
            chrono_q   <= chrono_d;
            saved_q    <= do_save ? chrono_q : saved_q;
            dout_q     <= do_dout || (dout_q && !dout_clr_i);
            vtt_q      <= vtt_d;
            vtt_busy_q <= (vtt_d != ctu_pkg::CTU_ZERO);
        end
    end

    // ********************************************************************
    // Registered outputs
    // ********************************************************************
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rec_start_o <= 1'b0;
            u1_fire_o   <= 1'b0;
            u2_fire_o   <= 1'b0;
        end else begin
            rec_start_o <= do_rec;
            u1_fire_o   <= u1_fire;
            u2_fire_o   <= u2_fire;
        end
    end

    assign chrono_run_o = run_q;
    assign chrono_o     = chrono_q;
    assign saved_o      = saved_q;
    assign dout_o       = dout_q;
    assign vtt_busy_o   = vtt_busy_q;
    assign armed_o      = armed_q;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_arm;
        arm;
    endsequence

    sequence s_expire;
        win_exp && !arm;
    endsequence

    sequence s_open_tick;
        armed_q && cascade && !arm && !u2_fire && !win_exp;
    endsequence

    sequence s_u2_take;
        cascade && u2_fire && !arm;
    endsequence

    sequence s_vtt_run;
        vtt_q != ctu_pkg::CTU_ZERO && !do_vtt;
    endsequence

    sequence s_chrono_run;
        run_q && !do_clr;
    endsequence

    a_window_open: assert property (
        s_arm |=> armed_o && win_q == $past(u1_cfg_i.vtt))
        else $error("Cascade window not opened with its length.");

    a_window_gate: assert property (
        cascade && u2_fire |-> armed_q)
        else $error("Unit 2 event taken outside the window.");

    a_window_reset: assert property (
        s_expire |=> !armed_o && win_q == ctu_pkg::CTU_ZERO)
        else $error("Cascade not reset on window expiry.");

    a_window_count: assert property (
        s_open_tick |=> armed_o && win_q == ctu_pkg::ctu_word_t'($past(win_q) - ctu_pkg::CTU_ONE))
        else $error("Cascade window not counting down.");

    a_window_close: assert property (
        s_u2_take |=> !armed_o && win_q == ctu_pkg::CTU_ZERO)
        else $error("Cascade window not closed by unit 2 event.");

    a_zero_window: assert property (
        cascade && u1_fire && u1_cfg_i.vtt == ctu_pkg::CTU_ZERO && !armed_q |=> !armed_o)
        else $error("Zero length window armed.");

    a_u2_blocked: assert property (
        u2_clear |-> !u2_fire)
        else $error("Unit 2 fired while cascade idle.");

    a_chrono_start: assert property (
        do_chrono |=> chrono_run_o [*2])
        else $error("Chronometer not started.");

    a_chrono_count: assert property (
        s_chrono_run |=> chrono_o == ctu_pkg::ctu_word_t'($past(chrono_o) + ctu_pkg::CTU_ONE))
        else $error("Chronometer not counting.");

    a_dout_set: assert property (
        do_dout |=> dout_o)
        else $error("Digital output not set.");

    a_dout_hold: assert property (
        dout_o && !dout_clr_i |=> dout_o)
        else $error("Digital output dropped without clear.");

    a_dout_clear: assert property (
        dout_clr_i && !do_dout |=> !dout_o)
        else $error("Digital output not cleared.");

    a_rec_start: assert property (
        $rose(u1_fire_o) && $past(u1_cfg_i.act) == ctu_pkg::CTU_ACT_REC |-> rec_start_o)
        else $error("Recording start not pulsed.");

    a_timer_clear: assert property (
        do_clr |=> chrono_o == ctu_pkg::CTU_ZERO)
        else $error("Timer not cleared.");

    a_timer_save: assert property (
        do_save |=> saved_o == $past(chrono_o))
        else $error("Timer value not stored.");

    a_vtt_start: assert property (
        do_vtt && vtt_load != ctu_pkg::CTU_ZERO |=> vtt_busy_o && vtt_q == $past(vtt_load))
        else $error("Valid time timer not started.");

    a_vtt_count: assert property (
        s_vtt_run |=> vtt_q == ctu_pkg::ctu_word_t'($past(vtt_q) - ctu_pkg::CTU_ONE))
        else $error("Valid time timer not counting down.");

    a_vtt_idle: assert property (
        vtt_q == ctu_pkg::CTU_ZERO && !do_vtt |=> !vtt_busy_o)
        else $error("Valid time timer busy while idle.");

endmodule

`default_nettype wire

// file: sim/ctu_coupler_model.sv
// Purpose: Fieldbus coupler model that writes trigger settings and the output word.
// Assumes: The bench calls its tasks just after a rising clock edge.
// Notes:   A write lands whole, so no edge ever sees half of a unit setting.

`default_nettype none

module ctu_coupler_model (
    output var ctu_pkg::ctu_cfg_t  u1_cfg_o,
    output var ctu_pkg::ctu_cfg_t  u2_cfg_o,
    output var ctu_pkg::ctu_word_t fb_word_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Coupler writes
    // ****************************************************************
    initial begin
        u1_cfg_o  = '0;
        u2_cfg_o  = '0;
        fb_word_o = 16'h0000;
    end

    // The first word index of a set picks the unit.
    task automatic load(input int first, input ctu_pkg::ctu_cfg_t c);
        if (first == ctu_pkg::CTU_U1_REG_FIRST) u1_cfg_o = c;
        else u2_cfg_o = c;
    endtask

    task automatic put_word(input ctu_pkg::ctu_word_t w);
        fb_word_o = w;
    endtask
endmodule

`default_nettype wire

// file: sim/test_ctu_top.sv
// Purpose: Self-checking bench for the two cascadable trigger units.
// Assumes: Inputs change 1 ns after a rising edge of mclk_i.
// Notes:   Levels and widths come from a fixed seed, so every run repeats.

`default_nettype none

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module test_ctu_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic               mclk_i    = 1'b0;
    logic               reset_n_i = 1'b0;
    logic               pin       = 1'b0;
    logic               dclr      = 1'b0;
    logic               follow    = 1'b1;
    logic               neg, g;
    ctu_pkg::ctu_word_t ana       = 16'h0000;
    ctu_pkg::ctu_word_t fbw, chrono, saved;
    ctu_pkg::ctu_cfg_t  c1, c2, u1_cfg, u2_cfg;
    logic               rec, run, dout, busy, armed, f1, f2;
    int                 fail_count = 0;
    int                 tests_run  = 0;
    int                 seed       = 32'hEAF4EFD0;
    int                 n1 = 0, n2 = 0, nrec = 0, nbusy = 0;
    int                 e, w, v, d, lat;
    wire ctu_pkg::ctu_smp_t smp;

    assign smp = {fbw, ana};

    always #10 mclk_i = ~mclk_i;

    // Pulses are counted at every rising edge so that no one-cycle output is missed.
    always @(posedge mclk_i) begin
        n1    <= n1 + int'(f1);
        n2    <= n2 + int'(f2);
        nrec  <= nrec + int'(rec);
        nbusy <= nbusy + int'(busy);
    end

    ctu_coupler_model cpl (.u1_cfg_o(u1_cfg), .u2_cfg_o(u2_cfg), .fb_word_o(fbw));

    ctu_top dut (
        .mclk_i       (mclk_i),
        .reset_n_i    (reset_n_i),
        .u1_cfg_i     (u1_cfg),
        .u2_cfg_i     (u2_cfg),
        .smp_i        (smp),
        .trig_pin_i   (pin),
        .dout_clr_i   (dclr),
        .rec_start_o  (rec),
        .chrono_run_o (run),
        .chrono_o     (chrono),
        .saved_o      (saved),
        .dout_o       (dout),
        .vtt_busy_o   (busy),
        .armed_o      (armed),
        .u1_fire_o    (f1),
        .u2_fire_o    (f2)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic clr();
        n1    = 0;
        n2    = 0;
        nrec  = 0;
        nbusy = 0;
    endtask

    // A low analog word is negative, so only a signed compare keeps it low.
    task automatic lvl(input logic l);
        logic [15:0] r;
        r = 16'($random(seed));
        cpl.put_word(l ? {4'h1, r[11:0]} : {8'h00, r[7:0]});
        ana = l ? {4'h1, r[11:0]} : {1'b1, r[14:0]};
        if (follow) pin = l;
    endtask

    task automatic load();
        cpl.load(ctu_pkg::CTU_U1_REG_FIRST, c1);
        cpl.load(ctu_pkg::CTU_U2_REG_FIRST, c2);
    endtask

    task automatic rise_wait();
        load();
        lvl(1'b0);
        tick(10);
        clr();
        lvl(1'b1);
        for (lat = 0; lat < 10 && f1 !== 1'b1; lat++) tick(1);
    endtask

    function automatic ctu_pkg::ctu_cfg_t base(input int s, input int ev, input int a);
        ctu_pkg::ctu_cfg_t c;
        c         = '0;
        c.src     = ctu_pkg::ctu_src_t'(s);
        c.evt     = ctu_pkg::ctu_evt_t'(ev);
        c.act     = ctu_pkg::ctu_act_t'(a);
        c.trg_thr = 16'h0100;
        c.pulse_w = 16'h0004;
        return c;
    endfunction

    function automatic int glitch_exp(input int ev, input int wd);
        if (ev == ctu_pkg::CTU_EVT_PLONG || ev == ctu_pkg::CTU_EVT_NLONG) return int'(wd > 4);
        return int'(wd < 4);
    endfunction

    function automatic int casc_exp(input int dl, input int vt);
        return int'(dl < vt);
    endfunction

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end

    initial begin
        tick(10);
        reset_n_i = 1'b1;
        tick(1);
        `CHK("outs after reset", 0, {rec, run, chrono, saved, dout, busy, armed, f1, f2})
        c2 = base(0, 0, ctu_pkg::CTU_ACT_NONE);
        // Timer source is left to the chronometer test below.
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 2; k++) begin
                if (s == 1) continue;
                c1 = base(s, k, ctu_pkg::CTU_ACT_REC);
                load();
                lvl(k[0]);
                tick(10);
                clr();
                lvl(!k[0]);
                tick(10);
                `CHK("edge fire", 1, n1)
                `CHK("record start", 1, nrec)
                clr();
                lvl(k[0]);
                tick(10);
                `CHK("opposite edge", 0, n1)
            end
        end
        // The first four pulses sit exactly at the set width.
        for (int k = 0; k < 12; k++) begin
            e   = 2 + k % 4;
            w   = (k < 4) ? 4 : 1 + ($random(seed) & 7);
            neg = e >= ctu_pkg::CTU_EVT_NLONG;
            c1  = base(0, e, ctu_pkg::CTU_ACT_REC);
            load();
            lvl(neg);
            tick(10);
            clr();
            lvl(!neg);
            tick(w);
            lvl(neg);
            tick(10);
            `CHK("glitch", glitch_exp(e, w), n1)
        end
        follow = 1'b0;
        for (int k = 0; k < 8; k++) begin
            g         = 1'($random(seed));
            c1        = base(0, 0, ctu_pkg::CTU_ACT_REC);
            c1.ena    = (k < 4) ? ctu_pkg::CTU_ENA_ANA : ctu_pkg::CTU_ENA_DIN;
            c1.en_neg = k[0];
            c1.en_thr = g ? 16'h1000 : 16'h7FFF;
            pin       = g;
            rise_wait();
            tick(10);
            `CHK("gated fire", g ^ k[0], n1)
        end
        follow = 1'b1;
        c1 = base(0, 0, ctu_pkg::CTU_ACT_CHRONO);
        c2 = base(ctu_pkg::CTU_SRC_TMR, 0, ctu_pkg::CTU_ACT_NONE);
        c2.trg_thr = 16'h0020;
        rise_wait();
        `CHK("fire latency", 2, lat)
        tick(60);
        `CHK("chrono running", 1, run)
        `CHK("timer source", 1, n2)
        c1.act = ctu_pkg::CTU_ACT_SAVE;
        rise_wait();
        `CHK("saved value", ctu_pkg::ctu_word_t'(chrono - ctu_pkg::CTU_ONE), saved)
        c1.act = ctu_pkg::CTU_ACT_CLR;
        rise_wait();
        `CHK("timer cleared", ctu_pkg::CTU_ZERO, chrono)
        c1.act = ctu_pkg::CTU_ACT_VTT;
        v = 2 + ($random(seed) & 15);
        c1.vtt = 16'(v);
        rise_wait();
        tick(40);
        `CHK("valid time", v, nbusy)
        c1.act = ctu_pkg::CTU_ACT_DOUT;
        rise_wait();
        tick(2);
        `CHK("output set", 1, dout)
        dclr = 1'b1;
        tick(1);
        dclr = 1'b0;
        tick(1);
        `CHK("output cleared", 0, dout)
        // Accept and reject alternate, so every reject but the last is followed by a re-arm.
        c1 = base(0, 0, ctu_pkg::CTU_ACT_NONE);
        c2 = base(ctu_pkg::CTU_SRC_U1, ctu_pkg::CTU_EVT_FALL, ctu_pkg::CTU_ACT_REC);
        for (int k = 0; k < 6; k++) begin
            v = 4 + ($random(seed) & 7);
            d = k[0] ? v + 2 : v - 1;
            c1.vtt = 16'(v);
            load();
            lvl(1'b0);
            tick(20);
            clr();
            lvl(1'b1);
            tick(d);
            `CHK("window open", casc_exp(d, v), armed)
            lvl(1'b0);
            tick(30);
            `CHK("cascade fire", casc_exp(d, v), n2)
            `CHK("cascade action", casc_exp(d, v), nrec)
            `CHK("window closed", 0, armed)
        end
        reset_n_i = 1'b0;
        tick(2);
        `CHK("outs in reset", 0, {rec, run, chrono, saved, dout, busy, armed, f1, f2})
        reset_n_i = 1'b1;
        tick(2);
        `CHK("chrono stopped", 0, run)
        print_verdict();
    end
endmodule

`default_nettype wire
